//--- inc/pgpio_pkg.sv
// package of constants, types and helpers for the port 1 / port 2 gpio block
package pgpio_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] P1_DATA_OFS = 8'h00;
   localparam logic [7:0] P1_DIR_OFS = 8'h04;
   localparam logic [7:0] P1_PULLUP_OFS = 8'h08;
   localparam logic [7:0] FUNC_SEL_OFS = 8'h0c;
   localparam logic [7:0] P2_DIR_OFS = 8'h10;
   localparam logic [7:0] P2_DATA_OFS = 8'h14;

   // ----------------------------------------------------------------
   // field layouts and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] P1_IMPL_MASK = 8'hf7;
   localparam logic [7:0] P1_RSVD_ONES = 8'h08;
   localparam logic [4:0] P2_IMPL_MASK = 5'h1f;
   localparam logic [2:0] P2_RSVD_ONES = 3'h7;
   localparam logic [7:0] P1_DATA_RST = 8'h00;
   localparam logic [7:0] P1_DIR_RST = 8'h00;
   localparam logic [7:0] P1_PULLUP_RST = 8'h00;
   localparam logic [7:0] FUNC_SEL_RST = 8'h00;
   localparam logic [4:0] P2_DIR_RST = 5'h00;
   localparam logic [4:0] P2_DATA_RST = 5'h00;
   localparam logic [7:0] WO_READ_VAL = 8'h00;

   // function select bit positions
   localparam int FS_EXT_INTERRUPT_3 = 7;
   localparam int FS_EXT_INTERRUPT_2 = 6;
   localparam int FS_EXT_INTERRUPT_1 = 5;
   localparam int FS_EXT_INTERRUPT_0 = 4;
   localparam int FS_TXD = 1;
   localparam int FS_PWM = 2;
   localparam int FS_CLKOUT = 0;

   // ----------------------------------------------------------------
   // state of the register file
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] p1_data;
      logic [7:0] p1_dir;
      logic [7:0] p1_pullup;
      logic [7:0] func_sel;
      logic [4:0] p2_dir;
      logic [4:0] p2_data;
      logic [31:0] prdata;
      logic pslverr;
   } pgpio_state_type;

   // stored value for outputs, live pin for inputs
   function automatic logic [7:0] pgpio_merge(input logic [7:0] stored,
                                             input logic [7:0] live,
                                             input logic [7:0] dir);
      pgpio_merge = (stored & dir) | (live & ~dir);
   endfunction

endpackage

//--- rtl/pgpio_port1_mux.sv
// port 1 pin function multiplexer
`timescale 1ns/1ns
module pgpio_port1_mux (
   input wire logic [7:0] data_i,
   input wire logic [7:0] dir_i,
   input wire logic [7:0] pullup_i,
   input wire logic [7:0] func_sel_i,
   input wire logic [7:0] pin_i,
   input wire logic pwm_i,
   input wire logic clock_output_i,
   output logic [7:0] pin_o,
   output logic [7:0] pin_oe_o,
   output logic [7:0] pullup_o,
   output logic [3:0] ext_interrupt_o,
   output logic timer_trigger_input_o,
   output logic timer_event_input_o
);

   // ----------------------------------------------------------------
   // per pin function choice
   // ----------------------------------------------------------------
   logic [7:0] alt_in;
   logic [7:0] alt_out;

   always_comb begin
      alt_in = {func_sel_i[pgpio_pkg::FS_EXT_INTERRUPT_3], func_sel_i[pgpio_pkg::FS_EXT_INTERRUPT_2],
                func_sel_i[pgpio_pkg::FS_EXT_INTERRUPT_1], func_sel_i[pgpio_pkg::FS_EXT_INTERRUPT_0], 4'h0};
      alt_out = {6'h00, func_sel_i[pgpio_pkg::FS_PWM], func_sel_i[pgpio_pkg::FS_CLKOUT]};
      // general pins follow direction and stored data
      pin_oe_o = ((dir_i & ~alt_in & ~alt_out) | alt_out) & pgpio_pkg::P1_IMPL_MASK;
      pin_o = (data_i & ~alt_out) & pgpio_pkg::P1_IMPL_MASK;
      pin_o[1] = alt_out[1] ? pwm_i : data_i[1];
      pin_o[0] = alt_out[0] ? clock_output_i : data_i[0];
      pullup_o = pullup_i & ~dir_i & pgpio_pkg::P1_IMPL_MASK;
      // interrupt inputs idle high when not selected
      ext_interrupt_o = (pin_i[7:4] & alt_in[7:4]) | ~alt_in[7:4];
      timer_trigger_input_o = alt_in[7] & pin_i[7];
      timer_event_input_o = alt_in[5] & pin_i[5];
   end

endmodule

//--- rtl/pgpio_port2_mux.sv
// port 2 pin function multiplexer with serial priority
`timescale 1ns/1ns
module pgpio_port2_mux (
   input wire logic [4:0] data_i,
   input wire logic [4:0] dir_i,
   input wire logic txd_sel_i,
   input wire logic [4:0] pin_i,
   input wire logic serial_txd_i,
   input wire logic serial_rx_en_i,
   input wire logic [1:0] serial_clk_mode_i,
   input wire logic serial_clk_sync_i,
   input wire logic serial_clk_out_i,
   output logic [4:0] pin_o,
   output logic [4:0] pin_oe_o,
   output logic serial_rxd_o,
   output logic serial_clk_in_o
);

   // ----------------------------------------------------------------
   // serial settings win over general direction
   // ----------------------------------------------------------------
   logic clk_in_mode;
   logic clk_out_mode;

   always_comb begin
      clk_in_mode = serial_clk_mode_i[1];
      clk_out_mode = !serial_clk_mode_i[1] &&
                     (serial_clk_mode_i[0] || serial_clk_sync_i);
      pin_oe_o = dir_i;
      pin_o = data_i;
      if (txd_sel_i) begin
         pin_oe_o[2] = 1'b1;
         pin_o[2] = serial_txd_i;
      end
      if (serial_rx_en_i) begin
         pin_oe_o[1] = 1'b0;
         pin_o[1] = 1'b0;
      end
      if (clk_in_mode) begin
         pin_oe_o[0] = 1'b0;
         pin_o[0] = 1'b0;
      end else if (clk_out_mode) begin
         pin_oe_o[0] = 1'b1;
         pin_o[0] = serial_clk_out_i;
      end
      serial_rxd_o = serial_rx_en_i ? pin_i[1] : 1'b1;
      serial_clk_in_o = clk_in_mode & pin_i[0];
   end

endmodule

//--- rtl/pgpio_top.sv
// register file and pin logic of the port 1 / port 2 gpio block
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns

// Overview of operation
// - port 1 data register holds output values; bits reset to 0
// - port 1 data read returns stored value where direction is output
// - port 1 data read returns live pin where direction is input
// - bit 3 of port 1 data and pull-up reads 1, writes ignored
// - pull-up acts only while the pin's direction bit is input
// - pull-up bit 1 turns pull-up on, 0 off; reset 0
// - bit 7 selected feeds interrupt 3 and timer trigger, ignoring direction
// - bit 5 selected feeds interrupt 1 and timer event, ignoring direction
// - port 2 function select and serial settings beat general I/O
// - port 2 direction 1 output, 0 input; write-only; reset 0
// - port 2 data bits 4..0 reset 0; bits 7..5 read 1
// - port 2 data read: stored where output, live pin where input
// - port 1 direction 1 output, 0 input; write-only; reset 0
// - function select bits reset 0, pins start as inputs
module pgpio_top (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [7:0] p1_pin_i,
   output logic [7:0] p1_pin_o,
   output logic [7:0] p1_pin_oe_o,
   output logic [7:0] p1_pullup_o,
   input wire logic [4:0] p2_pin_i,
   output logic [4:0] p2_pin_o,
   output logic [4:0] p2_pin_oe_o,
   input wire logic pwm_i,
   input wire logic clock_output_i,
   output logic [3:0] ext_interrupt_o,
   output logic timer_trigger_input_o,
   output logic timer_event_input_o,
   input wire logic serial_txd_i,
   input wire logic serial_rx_en_i,
   input wire logic [1:0] serial_clk_mode_i,
   input wire logic serial_clk_sync_i,
   input wire logic serial_clk_out_i,
   output logic serial_rxd_o,
   output logic serial_clk_in_o
);

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   pgpio_pkg::pgpio_state_type state_ff;
   pgpio_pkg::pgpio_state_type nxt_state;
   logic setup_ph;
   logic wr_acc;
   logic word_ok;
   logic hit_p1_data;
   logic hit_p1_dir;
   logic hit_p1_pullup;
   logic hit_func_sel;
   logic hit_p2_dir;
   logic hit_p2_data;
   logic mapped;
   logic [7:0] rd_byte;

   assign setup_ph = psel_i && !penable_i;
   assign wr_acc = psel_i && penable_i && pwrite_i && !state_ff.pslverr;
   assign word_ok = paddr_i[1:0] == 2'h0;
   assign hit_p1_data = word_ok && paddr_i == pgpio_pkg::P1_DATA_OFS;
   assign hit_p1_dir = word_ok && paddr_i == pgpio_pkg::P1_DIR_OFS;
   assign hit_p1_pullup = word_ok && paddr_i == pgpio_pkg::P1_PULLUP_OFS;
   assign hit_func_sel = word_ok && paddr_i == pgpio_pkg::FUNC_SEL_OFS;
   assign hit_p2_dir = word_ok && paddr_i == pgpio_pkg::P2_DIR_OFS;
   assign hit_p2_data = word_ok && paddr_i == pgpio_pkg::P2_DATA_OFS;
   assign mapped = hit_p1_data || hit_p1_dir || hit_p1_pullup || hit_func_sel ||
                   hit_p2_dir || hit_p2_data;

   // ----------------------------------------------------------------
   // read data selection
   // ----------------------------------------------------------------
   always_comb begin
      rd_byte = 8'h00;
      if (hit_p1_data) begin
         rd_byte = pgpio_pkg::pgpio_merge(state_ff.p1_data, p1_pin_i,
                                          state_ff.p1_dir);
         rd_byte = (rd_byte & pgpio_pkg::P1_IMPL_MASK) | pgpio_pkg::P1_RSVD_ONES;
      end else if (hit_p1_pullup) begin
         rd_byte = state_ff.p1_pullup | pgpio_pkg::P1_RSVD_ONES;
      end else if (hit_func_sel) begin
         rd_byte = state_ff.func_sel;
      end else if (hit_p1_dir || hit_p2_dir) begin
         rd_byte = pgpio_pkg::WO_READ_VAL;
      end else if (hit_p2_data) begin
         rd_byte = pgpio_pkg::pgpio_merge({3'h0, state_ff.p2_data},
                                          {3'h0, p2_pin_i},
                                          {3'h0, state_ff.p2_dir});
         rd_byte[7:5] = pgpio_pkg::P2_RSVD_ONES;
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      // read data and error are captured in the setup cycle
      if (setup_ph) begin
         nxt_state.prdata = pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
         nxt_state.pslverr = !mapped;
      end
      if (wr_acc && hit_p1_data) begin
         nxt_state.p1_data = pwdata_i[7:0] & pgpio_pkg::P1_IMPL_MASK;
      end
      if (wr_acc && hit_p1_dir) begin
         nxt_state.p1_dir = pwdata_i[7:0] & pgpio_pkg::P1_IMPL_MASK;
      end
      if (wr_acc && hit_p1_pullup) begin
         nxt_state.p1_pullup = pwdata_i[7:0] & pgpio_pkg::P1_IMPL_MASK;
      end
      if (wr_acc && hit_func_sel) begin
         nxt_state.func_sel = pwdata_i[7:0];
      end
      if (wr_acc && hit_p2_dir) begin
         nxt_state.p2_dir = pwdata_i[4:0] & pgpio_pkg::P2_IMPL_MASK;
      end
      if (wr_acc && hit_p2_data) begin
         nxt_state.p2_data = pwdata_i[4:0] & pgpio_pkg::P2_IMPL_MASK;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_ff.p1_data <= pgpio_pkg::P1_DATA_RST;
         state_ff.p1_dir <= pgpio_pkg::P1_DIR_RST;
         state_ff.p1_pullup <= pgpio_pkg::P1_PULLUP_RST;
         state_ff.func_sel <= pgpio_pkg::FUNC_SEL_RST;
         state_ff.p2_dir <= pgpio_pkg::P2_DIR_RST;
         state_ff.p2_data <= pgpio_pkg::P2_DATA_RST;
         state_ff.prdata <= 32'h0000_0000;
         state_ff.pslverr <= 1'b0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign prdata_o = state_ff.prdata;
   assign pslverr_o = state_ff.pslverr;
   assign pready_o = 1'b1;

   // ----------------------------------------------------------------
   // pin multiplexers
   // ----------------------------------------------------------------
   pgpio_port1_mux u_port1 (
      .data_i(state_ff.p1_data),
      .dir_i(state_ff.p1_dir),
      .pullup_i(state_ff.p1_pullup),
      .func_sel_i(state_ff.func_sel),
      .pin_i(p1_pin_i),
      .pwm_i(pwm_i),
      .clock_output_i(clock_output_i),
      .pin_o(p1_pin_o),
      .pin_oe_o(p1_pin_oe_o),
      .pullup_o(p1_pullup_o),
      .ext_interrupt_o(ext_interrupt_o),
      .timer_trigger_input_o(timer_trigger_input_o),
      .timer_event_input_o(timer_event_input_o)
   );

   pgpio_port2_mux u_port2 (
      .data_i(state_ff.p2_data),
      .dir_i(state_ff.p2_dir),
      .txd_sel_i(state_ff.func_sel[pgpio_pkg::FS_TXD]),
      .pin_i(p2_pin_i),
      .serial_txd_i(serial_txd_i),
      .serial_rx_en_i(serial_rx_en_i),
      .serial_clk_mode_i(serial_clk_mode_i),
      .serial_clk_sync_i(serial_clk_sync_i),
      .serial_clk_out_i(serial_clk_out_i),
      .pin_o(p2_pin_o),
      .pin_oe_o(p2_pin_oe_o),
      .serial_rxd_o(serial_rxd_o),
      .serial_clk_in_o(serial_clk_in_o)
   );

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   localparam int FS_EXT_INTERRUPT_3_LOCAL = pgpio_pkg::FS_EXT_INTERRUPT_3;

   sequence s_read_setup(logic hit);
      psel_i && !penable_i && !pwrite_i && hit;
   endsequence

   a_p1_data_store: assert property (
      wr_acc && hit_p1_data |=> state_ff.p1_data == ($past(pwdata_i[7:0]) & 8'hf7))
      else $error("port 1 data write not stored");

   a_p1_read_out: assert property (
      s_read_setup(hit_p1_data) |=>
         ((prdata_o[7:0] ^ state_ff.p1_data) & state_ff.p1_dir & 8'hf7) == 8'h00)
      else $error("port 1 output bit read wrong");

   a_p1_read_pin: assert property (
      s_read_setup(hit_p1_data) |=>
         ((prdata_o[7:0] ^ $past(p1_pin_i)) & ~state_ff.p1_dir & 8'hf7) == 8'h00)
      else $error("port 1 input bit read wrong");

   a_p1_bit3_one: assert property (
      s_read_setup(hit_p1_data || hit_p1_pullup) |=> prdata_o[3] && !state_ff.p1_data[3])
      else $error("port 1 bit 3 not read as one");

   a_pullup_gated: assert property (
      (p1_pullup_o & state_ff.p1_dir) == 8'h00)
      else $error("pull-up on an output pin");

   a_pullup_on: assert property (
      wr_acc && hit_p1_pullup && pwdata_i[0] && !state_ff.p1_dir[0] &&
      $stable(state_ff.p1_dir) |=> p1_pullup_o[0])
      else $error("pull-up not turned on");

   a_ext_interrupt_3_route: assert property (
      state_ff.func_sel[7] |-> !p1_pin_oe_o[7] && ext_interrupt_o[3] == p1_pin_i[7] &&
         timer_trigger_input_o == p1_pin_i[7])
      else $error("pin 7 alternate input wrong");

   a_ext_interrupt_1_route: assert property (
      state_ff.func_sel[5] |-> !p1_pin_oe_o[5] && ext_interrupt_o[1] == p1_pin_i[5] &&
         timer_event_input_o == p1_pin_i[5])
      else $error("pin 5 alternate input wrong");

   a_pwm_drive: assert property (
      state_ff.func_sel[2] |-> p1_pin_oe_o[1] && p1_pin_o[1] == pwm_i && !p1_pin_oe_o[2] ==
         !state_ff.p1_dir[2])
      else $error("pwm pin not driven");

   a_serial_prio: assert property (
      serial_rx_en_i |-> !p2_pin_oe_o[1] && serial_rxd_o == p2_pin_i[1])
      else $error("receive pin not released");

   a_p2_dir_write: assert property (
      wr_acc && hit_p2_dir && !state_ff.func_sel[1] |=>
         p2_pin_oe_o[2] == $past(pwdata_i[2]))
      else $error("port 2 direction not applied");

   a_p2_rsvd_ones: assert property (
      s_read_setup(hit_p2_data) |=> prdata_o[7:5] == 3'h7 && !pslverr_o)
      else $error("port 2 reserved bits not one");

   a_p2_read_mix: assert property (
      s_read_setup(hit_p2_data) |=>
         prdata_o[4:0] == (($past(p2_pin_i) & ~state_ff.p2_dir) |
                           (state_ff.p2_data & state_ff.p2_dir)))
      else $error("port 2 read value wrong");

   a_p1_dir_write: assert property (
      wr_acc && hit_p1_dir && !state_ff.func_sel[6] |=>
         p1_pin_oe_o[6] == $past(pwdata_i[6]))
      else $error("port 1 direction not applied");

   a_reset_inputs: assert property (
      $rose(rst_b_i) |-> state_ff.func_sel == 8'h00 && p1_pin_oe_o == 8'h00)
      else $error("pins not inputs after reset");

   a_gpio_drive: assert property (
      !state_ff.func_sel[FS_EXT_INTERRUPT_3_LOCAL] && state_ff.p1_dir[7] |->
         p1_pin_oe_o[7] && p1_pin_o[7] == state_ff.p1_data[7])
      else $error("general output not driven from data");

   // ----------------------------------------------------------------
   // alternate pins and refused accesses
   // ----------------------------------------------------------------
   a_ext_interrupt_2_route: assert property (
      state_ff.func_sel[6] |-> !p1_pin_oe_o[6] && ext_interrupt_o[2] == p1_pin_i[6])
      else $error("pin 6 alternate input wrong");

   a_irq_idle: assert property (
      !state_ff.func_sel[4] |-> ext_interrupt_o[0])
      else $error("unselected interrupt not idle");

   a_clkout_drive: assert property (
      state_ff.func_sel[0] |-> p1_pin_oe_o[0] && p1_pin_o[0] == clock_output_i)
      else $error("clock output pin not driven");

   a_bit3_unused: assert property (
      !state_ff.p1_data[3] && !state_ff.p1_pullup[3] && !p1_pullup_o[3] &&
         !p1_pin_oe_o[3])
      else $error("port 1 bit 3 holds a value");

   a_txd_drive: assert property (
      state_ff.func_sel[1] |-> p2_pin_oe_o[2] && p2_pin_o[2] == serial_txd_i)
      else $error("transmit pin not driven");

   a_clk_in_prio: assert property (
      serial_clk_mode_i[1] |-> !p2_pin_oe_o[0] && serial_clk_in_o == p2_pin_i[0])
      else $error("clock input pin not released");

   a_p2_data_store: assert property (
      wr_acc && hit_p2_data |=> state_ff.p2_data == $past(pwdata_i[4:0]))
      else $error("port 2 data write not stored");

   a_upper_zero: assert property (
      s_read_setup(mapped) |=> prdata_o[31:8] == 24'h00_0000 && !pslverr_o)
      else $error("read data upper bits not zero");

   a_refused_write: assert property (
      psel_i && penable_i && pwrite_i && pslverr_o |=> $stable(state_ff.p1_data) &&
         $stable(state_ff.p1_pullup) && $stable(state_ff.func_sel) &&
         $stable(state_ff.p2_data))
      else $error("refused write changed a register");

   c_p1_write: cover property (wr_acc && hit_p1_data);
   c_p2_read: cover property (s_read_setup(hit_p2_data) ##1 pready_o);
   c_unmapped: cover property (setup_ph && !mapped ##1 pslverr_o);
   c_irq_select: cover property (state_ff.func_sel[7] && !p1_pin_i[7]);
   c_clk_in: cover property (serial_clk_mode_i[1] && p2_pin_i[0]);

endmodule

//--- verification/pgpio_pin_model.sv
// pin and far-side level model for the port 1 / port 2 gpio block
`timescale 1ns/1ns
module pgpio_pin_model (
   input wire logic clk_i,
   input wire logic [7:0] p1_drv_i,
   input wire logic [7:0] p1_oe_i,
   input wire logic [7:0] p1_pu_i,
   input wire logic [7:0] p1_ext_i,
   input wire logic [7:0] p1_ext_en_i,
   input wire logic [4:0] p2_drv_i,
   input wire logic [4:0] p2_oe_i,
   input wire logic [4:0] p2_ext_i,
   input wire logic [4:0] p2_ext_en_i,
   output logic [7:0] p1_pin_o,
   output logic [4:0] p2_pin_o
);
   // ----------------------------------------------------------------
   // wire resolution
   // ----------------------------------------------------------------
   logic [7:0] p1_last_ff;
   logic [4:0] p2_last_ff;
   logic [7:0] p1_free;
   logic [4:0] p2_free;

   // chip driver wins, then outside driver, then pull-up on port 1 only, else drift
   assign p1_free = ~p1_oe_i & ~p1_ext_en_i;
   assign p1_pin_o = (p1_oe_i & p1_drv_i) | (~p1_oe_i & p1_ext_en_i & p1_ext_i)
      | (p1_free & p1_pu_i) | (p1_free & ~p1_pu_i & ~p1_last_ff);
   assign p2_free = ~p2_oe_i & ~p2_ext_en_i;
   assign p2_pin_o = (p2_oe_i & p2_drv_i) | (~p2_oe_i & p2_ext_en_i & p2_ext_i)
      | (p2_free & ~p2_last_ff);

   // undriven lines without pull-up show the inverse of their last level
   always_ff @(posedge clk_i) begin
      p1_last_ff <= p1_pin_o;
      p2_last_ff <= p2_pin_o;
   end
endmodule

//--- verification/pgpio_top_tb.sv
// self-checking testbench of the port 1 / port 2 gpio block
`timescale 1ns/1ns
module pgpio_top_tb;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic clk_i, rst_b_i, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, p1_i, p1_o, p1_oe, p1_pu, e1, e1en;
   logic [31:0] pwdata, prdata;
   logic [4:0] p2_i, p2_o, p2_oe, e2, e2en;
   logic pwm, clko, trig, evt, txd, rxen, sync, sclko, rxd, sclki;
   logic [1:0] cmode;
   logic [3:0] irq;
   int num_errors, total_checks;

   pgpio_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .p1_pin_i(p1_i),
      .p1_pin_o(p1_o), .p1_pin_oe_o(p1_oe), .p1_pullup_o(p1_pu), .p2_pin_i(p2_i),
      .p2_pin_o(p2_o), .p2_pin_oe_o(p2_oe), .pwm_i(pwm), .clock_output_i(clko),
      .ext_interrupt_o(irq), .timer_trigger_input_o(trig),
      .timer_event_input_o(evt), .serial_txd_i(txd), .serial_rx_en_i(rxen),
      .serial_clk_mode_i(cmode), .serial_clk_sync_i(sync),
      .serial_clk_out_i(sclko), .serial_rxd_o(rxd), .serial_clk_in_o(sclki));

   pgpio_pin_model pins_u (.clk_i(clk_i), .p1_drv_i(p1_o), .p1_oe_i(p1_oe),
      .p1_pu_i(p1_pu), .p1_ext_i(e1), .p1_ext_en_i(e1en), .p2_drv_i(p2_o),
      .p2_oe_i(p2_oe), .p2_ext_i(e2), .p2_ext_en_i(e2en), .p1_pin_o(p1_i),
      .p2_pin_o(p2_i));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic print_verdict;
      if (num_errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] r, output logic e);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         chk("pready wait", 8'h01, 8'h00);
         print_verdict();
      end
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chk("write error", 8'h00, {7'h00, e});
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] r;
      logic e;
      apb(1'b0, a, 8'h00, r, e);
      chk("read data", exp, r);
      chk("read error", 8'h00, {7'h00, e});
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      chk("p1 oe", 8'h00, p1_oe);
      chk("p1 pullup", 8'h00, p1_pu);
      chk("irq", 8'h0f, {4'h0, irq});
      chk("p2 oe", 8'h00, {3'h0, p2_oe});
      rd(pgpio_pkg::P1_DATA_OFS, 8'had);
      rd(pgpio_pkg::P1_PULLUP_OFS, 8'h08);
      rd(pgpio_pkg::FUNC_SEL_OFS, 8'h00);
      rd(pgpio_pkg::P1_DIR_OFS, pgpio_pkg::WO_READ_VAL);
      rd(pgpio_pkg::P2_DIR_OFS, pgpio_pkg::WO_READ_VAL);
      rd(pgpio_pkg::P2_DATA_OFS, 8'hea);
      wr(pgpio_pkg::P1_DIR_OFS, 8'hff);
      wr(pgpio_pkg::P2_DIR_OFS, 8'h1f);
      rd(pgpio_pkg::P1_DATA_OFS, 8'h08);
      rd(pgpio_pkg::P2_DATA_OFS, 8'he0);
   endtask

   task automatic t_port1;
      wr(pgpio_pkg::P1_DIR_OFS, 8'hf0);
      wr(pgpio_pkg::P1_DATA_OFS, 8'h5c);
      e1 <= 8'h0f;
      rd(pgpio_pkg::P1_DATA_OFS, 8'h5f);
      chk("p1 oe", 8'hf0, p1_oe);
      chk("p1 out", 8'h50, p1_o & 8'hf0);
   endtask

   task automatic t_pullup;
      wr(pgpio_pkg::P1_DIR_OFS, 8'h0f);
      wr(pgpio_pkg::P1_PULLUP_OFS, 8'hf7);
      e1en <= 8'h00;
      rd(pgpio_pkg::P1_PULLUP_OFS, 8'hff);
      chk("p1 pullup", 8'hf0, p1_pu);
      rd(pgpio_pkg::P1_DATA_OFS, 8'hfc);
      wr(pgpio_pkg::P1_PULLUP_OFS, 8'h00);
      rd(pgpio_pkg::P1_PULLUP_OFS, 8'h08);
      chk("p1 pullup", 8'h00, p1_pu);
   endtask

   task automatic t_func;
      wr(pgpio_pkg::P1_DIR_OFS, 8'hff);
      pwm <= 1'b1;
      e1 <= 8'ha0;
      e1en <= 8'hff;
      wr(pgpio_pkg::FUNC_SEL_OFS, 8'hf5);
      rd(pgpio_pkg::FUNC_SEL_OFS, 8'hf5);
      chk("p1 oe", 8'h07, p1_oe);
      chk("p1 out", 8'h06, p1_o & 8'h07);
      chk("irq", 8'h0a, {4'h0, irq});
      chk("trigger", 8'h01, {7'h00, trig});
      chk("event", 8'h01, {7'h00, evt});
      e1 <= 8'h50;
      clko <= 1'b1;
      @(posedge clk_i);
      chk("irq", 8'h05, {4'h0, irq});
      chk("trigger", 8'h00, {7'h00, trig});
      chk("event", 8'h00, {7'h00, evt});
      chk("p1 out", 8'h07, p1_o & 8'h07);
      wr(pgpio_pkg::FUNC_SEL_OFS, 8'h00);
      chk("irq", 8'h0f, {4'h0, irq});
      chk("p1 oe", 8'hf7, p1_oe);
   endtask

   task automatic t_port2;
      wr(pgpio_pkg::P2_DATA_OFS, 8'h15);
      chk("p2 oe", 8'h1f, {3'h0, p2_oe});
      chk("p2 out", 8'h15, {3'h0, p2_o});
      rd(pgpio_pkg::P2_DATA_OFS, 8'hf5);
      wr(pgpio_pkg::P2_DIR_OFS, 8'h03);
      e2 <= 5'h1c;
      rd(pgpio_pkg::P2_DATA_OFS, 8'hfd);
      wr(pgpio_pkg::FUNC_SEL_OFS, 8'h02);
      txd <= 1'b1;
      rxen <= 1'b1;
      cmode <= 2'b10;
      e2 <= 5'h02;
      @(posedge clk_i);
      chk("p2 oe", 8'h04, {3'h0, p2_oe});
      chk("p2 out", 8'h04, {3'h0, p2_o & 5'h04});
      chk("rxd", 8'h01, {7'h00, rxd});
      chk("clk in", 8'h00, {7'h00, sclki});
      cmode <= 2'b01;
      sclko <= 1'b1;
      rxen <= 1'b0;
      @(posedge clk_i);
      chk("p2 oe", 8'h07, {3'h0, p2_oe});
      chk("p2 out", 8'h05, {3'h0, p2_o & 5'h07});
      cmode <= 2'b00;
      sync <= 1'b1;
      sclko <= 1'b0;
      @(posedge clk_i);
      chk("p2 oe", 8'h07, {3'h0, p2_oe});
      chk("p2 out", 8'h04, {3'h0, p2_o & 5'h07});
      cmode <= 2'b10;
      sync <= 1'b0;
      e2 <= 5'h01;
      @(posedge clk_i);
      chk("clk in", 8'h01, {7'h00, sclki});
      chk("p2 oe", 8'h06, {3'h0, p2_oe});
      cmode <= 2'b00;
   endtask

   task automatic t_refused;
      logic [7:0] r;
      logic e;
      apb(1'b1, 8'h18, 8'h55, r, e);
      chk("unmapped error", 8'h01, {7'h00, e});
      apb(1'b1, 8'h09, 8'hff, r, e);
      chk("unaligned error", 8'h01, {7'h00, e});
      apb(1'b0, 8'h02, 8'h00, r, e);
      chk("unaligned error", 8'h01, {7'h00, e});
      chk("unaligned data", 8'h00, r);
      rd(pgpio_pkg::P1_PULLUP_OFS, 8'h08);
   endtask

   // ----------------------------------------------------------------
   // clock, reset and main sequence
   // ----------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   initial begin
      num_errors = 0;
      total_checks = 0;
      rst_b_i = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {pwm, clko, txd, rxen, sync, sclko, cmode} = '0;
      e1 = 8'ha5;
      e1en = 8'hff;
      e2 = 5'h0a;
      e2en = 5'h1f;
      repeat (5) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      t_reset();
      t_port1();
      t_pullup();
      t_func();
      t_port2();
      t_refused();
      print_verdict();
   end
endmodule
